/* File: dv/iec_bus_model.sv */
// iec_bus_model: two-wire bus peer that sends one framed byte: start, 8 bits, stop.
// assumes pull-ups on both lines, so they idle high; the clock stands still between frames.
`timescale 1ns/10ps
module iec_bus_model (
    output logic scl_out,
    output logic sda_out
);
    localparam int HALF = 80;

    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // data moves only while the clock is low, so no false start or stop appears mid-frame
    task automatic frame(input logic [7:0] data);
        int i;
        // step off the system clock edge so the pins never change as they are sampled
        #3;
        sda_out = 1'b0;
        #HALF scl_out = 1'b0;
        for (i = 7; i >= 0; i--) begin
            #(HALF/2) sda_out = data[i];
            #(HALF/2) scl_out = 1'b1;
            #HALF scl_out = 1'b0;
        end
        #(HALF/2) sda_out = 1'b0;
        #(HALF/2) scl_out = 1'b1;
        #HALF sda_out = 1'b1;
        #HALF;
    endtask : frame
endmodule : iec_bus_model

/* File: dv/testbench.sv */
// testbench: register-level checks of the event status block over Avalon-MM.
// assumes the bus peer model drives scl and sda; event inputs come from ev.
`timescale 1ns/10ps
module testbench
    import iec_pkg::*;
;
    logic              mclk_in = 1'b0;
    logic              rst_in  = 1'b1;
    logic [ADDR_W-1:0] addr    = '0;
    logic              rd      = 1'b0;
    logic              wr      = 1'b0;
    logic [DATA_W-1:0] wdata   = '0;
    logic [3:0]        be      = 4'h0;
    logic [DATA_W-1:0] rdata;
    logic              wait_rq;
    logic              scl;
    logic              sda;
    logic [EV_W-1:0]   ev      = '0;
    logic [ABORT_W-1:0] reason = '0;
    logic [7:0]        tx_lvl  = 8'h00;
    logic [7:0]        rx_lvl  = 8'h00;
    logic              irq;
    int                fails   = 0;
    int                n_checks = 0;
    localparam int        BITS [7] = '{0, 1, 3, 5, 6, 7, 11};
    localparam iec_addr_t CLRS [7] = '{OFF_CLR_RXUND, OFF_CLR_RXOVR, OFF_CLR_TXOVR,
        OFF_CLR_RDREQ, OFF_CLR_ABORT, OFF_CLR_NACK, OFF_CLR_ALL};

    always #10 mclk_in = ~mclk_in;

    iec_bus_model peer (.scl_out(scl), .sda_out(sda));

    iec_event_ctrl uut (
        .mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .scl_in(scl), .sda_in(sda),
        .broadcast_addr_hit_in(ev[EV_BCAST]), .bus_active_in(ev[EV_ACTIVITY]),
        .slave_tx_nack_in(ev[EV_NACK]), .transmit_abort_in(ev[EV_ABORT]),
        .abort_reason_in(reason), .read_request_in(ev[EV_RD_REQ]),
        .tx_cmd_when_full_in(ev[EV_TX_OVER]), .rx_byte_when_full_in(ev[EV_RX_OVER]),
        .rx_read_when_empty_in(ev[EV_RX_UNDER]), .tx_level_in(tx_lvl),
        .rx_level_in(rx_lvl), .interrupt_out(irq)
    );

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one access, held until waitrequest is sampled low
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] lanes, output logic [31:0] q);
        @(posedge mclk_in);
        addr  <= a;
        wdata <= d;
        be    <= lanes;
        rd    <= ~we;
        wr    <= we;
        // only the watchdog ends a wait that never completes
        do begin
            @(posedge mclk_in);
        end while (wait_rq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : acc

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, 4'h0, q);
        check(q, exp);
    endtask : rdc

    task automatic wrr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] lanes);
        logic [31:0] q;
        acc(1'b1, a, d, lanes, q);
    endtask : wrr

    task automatic pulse(input int b);
        @(posedge mclk_in);
        ev[b] <= 1'b1;
        @(posedge mclk_in);
        ev[b] <= 1'b0;
    endtask : pulse

    // both fifo levels are zero here, so both level bits pass their zero thresholds
    task automatic t_reset;
        rdc(OFF_MASK, 32'h8ff);
        rdc(OFF_RX_THR, 32'h0);
        rdc(OFF_TX_THR, 32'h0);
        rdc(OFF_RAW, 32'h014);
        rdc(OFF_MASKED, 32'h014);
        check(irq, 1'b1);
    endtask : t_reset

    task automatic t_thr;
        wrr(OFF_RX_THR, 32'hffffff05, 4'hf);
        rdc(OFF_RX_THR, 32'h05);
        wrr(OFF_TX_THR, 32'h03, 4'hf);
        rdc(OFF_TX_THR, 32'h03);
        @(posedge mclk_in);
        rx_lvl <= 8'h04;
        tx_lvl <= 8'h03;
        rdc(OFF_RAW, 32'h010);
        @(posedge mclk_in);
        rx_lvl <= 8'h05;
        tx_lvl <= 8'h04;
        rdc(OFF_RAW, 32'h004);
        @(posedge mclk_in);
        rx_lvl <= 8'h04;
        rdc(OFF_RAW, 32'h0);
    endtask : t_thr

    task automatic t_events;
        int i;
        for (i = 0; i < 7; i++) begin
            pulse(BITS[i]);
            rdc(OFF_RAW, 32'h1 << BITS[i]);
            rdc(CLRS[i], 32'h0);
            rdc(OFF_RAW, 32'h0);
        end
    endtask : t_events

    // the clear must not take while the controller is still busy on the bus
    task automatic t_activity;
        @(posedge mclk_in);
        ev[EV_ACTIVITY] <= 1'b1;
        rdc(OFF_CLR_ACT, 32'h0);
        rdc(OFF_RAW, 32'h100);
        @(posedge mclk_in);
        ev[EV_ACTIVITY] <= 1'b0;
        rdc(OFF_RAW, 32'h100);
        rdc(OFF_CLR_ACT, 32'h0);
        rdc(OFF_RAW, 32'h0);
    endtask : t_activity

    task automatic t_frame;
        peer.frame(8'ha5);
        repeat (8) @(posedge mclk_in);
        rdc(OFF_RAW, 32'h600);
        rdc(OFF_CLR_START, 32'h0);
        rdc(OFF_RAW, 32'h200);
        rdc(OFF_CLR_STOP, 32'h0);
        rdc(OFF_RAW, 32'h0);
    endtask : t_frame

    task automatic t_abort;
        reason <= 17'h00005;
        pulse(EV_ABORT);
        rdc(OFF_ABORT_SRC, 32'h5);
        rdc(OFF_CLR_ABORT, 32'h0);
        rdc(OFF_ABORT_SRC, 32'h0);
        reason <= 17'h00002;
        pulse(EV_ABORT);
        pulse(EV_RX_UNDER);
        pulse(EV_TX_OVER);
        rdc(OFF_RAW, 32'h049);
        rdc(OFF_CLR_ALL, 32'h0);
        rdc(OFF_RAW, 32'h0);
        rdc(OFF_ABORT_SRC, 32'h0);
    endtask : t_abort

    task automatic t_mask;
        wrr(OFF_MASK, 32'h0, 4'h1);
        rdc(OFF_MASK, 32'h800);
        wrr(OFF_MASK, 32'h0, 4'h2);
        rdc(OFF_MASK, 32'h0);
        pulse(EV_RX_OVER);
        rdc(OFF_MASKED, 32'h0);
        check(irq, 1'b0);
        wrr(OFF_RAW, 32'hffffffff, 4'hf);
        rdc(OFF_RAW, 32'h002);
        wrr(OFF_MASK, 32'h002, 4'h3);
        rdc(OFF_MASKED, 32'h002);
        check(irq, 1'b1);
        rdc(8'h90, 32'h0);
    endtask : t_mask

    initial begin
        #200us;
        fails++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_thr();
        t_events();
        t_activity();
        t_frame();
        t_abort();
        t_mask();
        stop_test();
    end
endmodule : testbench

/* File: verilog/iec_event_ctrl.sv */
// iec_event_ctrl: latched event status, per-event mask, fifo thresholds and
// clear-on-read registers of a two-wire serial bus controller, on Avalon-MM.
// assumes event pulses and fifo levels come from logic on mclk_in; the bus
// lines scl_in and sda_in are asynchronous and are resynchronised here.
//
// Summary of operation
// - one read-write mask bit per event; overflow and underflow masks reset to one
// - bit 11 latches when a broadcast address is received and acknowledged
// - bit 10 latches on every start or repeated start seen on the bus
// - bit 9 latches on every stop seen on the bus
// - bit 8 latches bus activity and stays until cleared
// - bit 7 latches when a remote master refuses a byte we sent as slave
// - bit 6 latches when a transmission aborts
// - bit 5 latches when a remote master reads from us as slave
// - bit 4 is high while transmit fifo level is at or below threshold
// - bit 3 latches on a command write into a full transmit fifo
// - bit 2 is high while receive fifo level reaches the receive threshold
// - bit 1 latches when a byte arrives at a full receive fifo
// - bit 0 latches when software reads data with the receive fifo empty
// - 8-bit receive and transmit thresholds at 0x38 and 0x3c, reset zero
// - reading clear-all clears every latched event (activity only when the bus is idle) and the abort source
// - reads of 0x44, 0x48, 0x4c clear underflow, overflow, transmit overflow
// - reads of 0x50 and 0x58 clear read request and slave nack
// - read of 0x54 clears abort event and abort source register
// - read of 0x5c clears activity only when the bus is idle
// - reads of 0x60 and 0x64 clear stop and start events
// - masked status at 0x2c is raw status gated by mask, same bits
`timescale 1ns/10ps
module iec_event_ctrl
    import iec_pkg::*;
#(
    parameter int LEVEL_W = 8
) (
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    input  wire logic [ADDR_W-1:0]  avs_address_in,
    input  wire logic               avs_read_in,
    input  wire logic               avs_write_in,
    input  wire logic [DATA_W-1:0]  avs_writedata_in,
    input  wire logic [3:0]         avs_byteenable_in,
    output logic      [DATA_W-1:0]  avs_readdata_out,
    output logic                    avs_waitrequest_out,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    input  wire logic               broadcast_addr_hit_in,
    input  wire logic               bus_active_in,
    input  wire logic               slave_tx_nack_in,
    input  wire logic               transmit_abort_in,
    input  wire logic [ABORT_W-1:0] abort_reason_in,
    input  wire logic               read_request_in,
    input  wire logic               tx_cmd_when_full_in,
    input  wire logic               rx_byte_when_full_in,
    input  wire logic               rx_read_when_empty_in,
    input  wire logic [LEVEL_W-1:0] tx_level_in,
    input  wire logic [LEVEL_W-1:0] rx_level_in,
    output logic                    interrupt_out
);

    generate
        if (LEVEL_W < 1 || LEVEL_W > THR_W) begin : g_bad_level
            $error("iec_event_ctrl: LEVEL_W must lie between 1 and THR_W");
        end
    endgenerate

    function automatic logic iec_hit(input iec_addr_t addr, input iec_addr_t off);
        iec_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : iec_hit

    // bus line resynchronisers
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       scl_fil;
    logic       sda_fil;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
        end
    end

    // a change is accepted only once stages two and three agree
    wire next_scl_fil = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_fil;
    wire next_sda_fil = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_fil;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_fil <= 1'b1;
            sda_fil <= 1'b1;
        end else begin
            scl_fil <= next_scl_fil;
            sda_fil <= next_sda_fil;
        end
    end

    // data moving while clock stays high marks a start or a stop
    wire scl_high_hold = scl_fil & next_scl_fil;
    wire start_seen    = scl_high_hold & sda_fil & ~next_sda_fil;
    wire stop_seen     = scl_high_hold & ~sda_fil & next_sda_fil;

    // bus slave: one wait cycle, then the access completes
    logic [DATA_W-1:0]  rd_data;
    iec_ev_t            raw_event_status;
    iec_ev_t            event_mask;
    iec_thr_t           receive_threshold;
    iec_thr_t           transmit_threshold;
    logic [ABORT_W-1:0] abort_source_register;

    wire     bus_req      = avs_read_in | avs_write_in;
    wire     bus_accept   = bus_req & ~avs_waitrequest_out;
    wire     rd_accept    = avs_read_in & ~avs_waitrequest_out;
    wire     wr_accept    = avs_write_in & ~avs_waitrequest_out;
    wire     snap_rd      = avs_read_in & avs_waitrequest_out;
    wire     next_waitreq = ~(bus_req & avs_waitrequest_out);

    wire iec_ev_t masked_event_status = raw_event_status & event_mask;

    assign rd_data =
        iec_hit(avs_address_in, OFF_MASKED)    ? DATA_W'(masked_event_status)   :
        iec_hit(avs_address_in, OFF_RAW)       ? DATA_W'(raw_event_status)      :
        iec_hit(avs_address_in, OFF_MASK)      ? DATA_W'(event_mask)            :
        iec_hit(avs_address_in, OFF_RX_THR)    ? DATA_W'(receive_threshold)     :
        iec_hit(avs_address_in, OFF_TX_THR)    ? DATA_W'(transmit_threshold)    :
        iec_hit(avs_address_in, OFF_ABORT_SRC) ? DATA_W'(abort_source_register) :
        '0;  // clear registers and unmapped words read as zero

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= '0;
        end else begin
            avs_waitrequest_out <= next_waitreq;
            if (snap_rd) begin
                avs_readdata_out <= rd_data;
            end
        end
    end

    // register writes take effect at the completing edge only
    wire wr_mask   = wr_accept & iec_hit(avs_address_in, OFF_MASK);
    wire wr_rx_thr = wr_accept & iec_hit(avs_address_in, OFF_RX_THR) & avs_byteenable_in[0];
    wire wr_tx_thr = wr_accept & iec_hit(avs_address_in, OFF_TX_THR) & avs_byteenable_in[0];

    wire iec_ev_t next_event_mask = {
        avs_byteenable_in[1] & wr_mask ? avs_writedata_in[EV_W-1:MASK_LO_W]
                                       : event_mask[EV_W-1:MASK_LO_W],
        avs_byteenable_in[0] & wr_mask ? avs_writedata_in[MASK_LO_W-1:0]
                                       : event_mask[MASK_LO_W-1:0]};

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            event_mask         <= MASK_RST;
            receive_threshold  <= THR_RST;
            transmit_threshold <= THR_RST;
        end else begin
            event_mask <= next_event_mask;
            if (wr_rx_thr) begin
                receive_threshold <= avs_writedata_in[THR_W-1:0];
            end
            if (wr_tx_thr) begin
                transmit_threshold <= avs_writedata_in[THR_W-1:0];
            end
        end
    end

    // clear-on-read decode; side effects happen only at the completing edge
    wire clr_all   = rd_accept & iec_hit(avs_address_in, OFF_CLR_ALL);
    wire clr_rxund = rd_accept & iec_hit(avs_address_in, OFF_CLR_RXUND);
    wire clr_rxovr = rd_accept & iec_hit(avs_address_in, OFF_CLR_RXOVR);
    wire clr_txovr = rd_accept & iec_hit(avs_address_in, OFF_CLR_TXOVR);
    wire clr_rdreq = rd_accept & iec_hit(avs_address_in, OFF_CLR_RDREQ);
    wire clr_abort = rd_accept & iec_hit(avs_address_in, OFF_CLR_ABORT);
    wire clr_nack  = rd_accept & iec_hit(avs_address_in, OFF_CLR_NACK);
    wire clr_act   = rd_accept & iec_hit(avs_address_in, OFF_CLR_ACT);
    wire clr_stop  = rd_accept & iec_hit(avs_address_in, OFF_CLR_STOP);
    wire clr_start = rd_accept & iec_hit(avs_address_in, OFF_CLR_START);

    // nets, since each bit has its own continuous driver
    wire iec_ev_t ev_set;
    wire iec_ev_t ev_clr;
    wire iec_ev_t next_raw;

    wire iec_thr_t tx_level_ext = iec_thr_t'(tx_level_in);
    wire iec_thr_t rx_level_ext = iec_thr_t'(rx_level_in);

    assign ev_set[EV_RX_UNDER] = rx_read_when_empty_in;
    assign ev_set[EV_RX_OVER]  = rx_byte_when_full_in;
    assign ev_set[EV_RX_LEVEL] = rx_level_ext >= receive_threshold;
    assign ev_set[EV_TX_OVER]  = tx_cmd_when_full_in;
    assign ev_set[EV_TX_LEVEL] = tx_level_ext <= transmit_threshold;
    assign ev_set[EV_RD_REQ]   = read_request_in;
    assign ev_set[EV_ABORT]    = transmit_abort_in;
    assign ev_set[EV_NACK]     = slave_tx_nack_in;
    assign ev_set[EV_ACTIVITY] = bus_active_in;
    assign ev_set[EV_STOP]     = stop_seen;
    assign ev_set[EV_START]    = start_seen;
    assign ev_set[EV_BCAST]    = broadcast_addr_hit_in;

    assign ev_clr[EV_RX_UNDER] = clr_all | clr_rxund;
    assign ev_clr[EV_RX_OVER]  = clr_all | clr_rxovr;
    assign ev_clr[EV_RX_LEVEL] = 1'b0;
    assign ev_clr[EV_TX_OVER]  = clr_all | clr_txovr;
    assign ev_clr[EV_TX_LEVEL] = 1'b0;
    assign ev_clr[EV_RD_REQ]   = clr_all | clr_rdreq;
    assign ev_clr[EV_ABORT]    = clr_all | clr_abort;
    assign ev_clr[EV_NACK]     = clr_all | clr_nack;
    // an active bus keeps the activity bit through any clear
    assign ev_clr[EV_ACTIVITY] = (clr_all | clr_act) & ~bus_active_in;
    assign ev_clr[EV_STOP]     = clr_all | clr_stop;
    assign ev_clr[EV_START]    = clr_all | clr_start;
    assign ev_clr[EV_BCAST]    = clr_all;

    // latched bits: a set in the clearing cycle wins; level bits just follow
    genvar gi;
    generate
        for (gi = 0; gi < EV_W; gi++) begin : g_event
            if (LEVEL_BITS[gi]) begin : g_level
                assign next_raw[gi] = ev_set[gi];
            end else begin : g_sticky
                assign next_raw[gi] = ev_set[gi] | (raw_event_status[gi] & ~ev_clr[gi]);
            end
        end
    endgenerate

    // reason bits gather with each abort; clearing with a new abort keeps the new reasons
    wire clr_src = clr_all | clr_abort;
    wire [ABORT_W-1:0] next_abort_src =
        (clr_src ? '0 : abort_source_register) |
        (transmit_abort_in ? abort_reason_in : '0);

    // interrupt follows the next state so it lines up with the status bits
    wire next_interrupt = |(next_raw & next_event_mask);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            raw_event_status      <= '0;
            abort_source_register <= '0;
            interrupt_out         <= 1'b0;
        end else begin
            raw_event_status      <= next_raw;
            abort_source_register <= next_abort_src;
            interrupt_out         <= next_interrupt;
        end
    end

    // checks
    default clocking iec_cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    property p_mask_reset;
        $past(rst_in) |-> event_mask[EV_RX_OVER:EV_RX_UNDER] == 2'h3;
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("mask reset value wrong");

    property p_bcast;
        broadcast_addr_hit_in |=> raw_event_status[EV_BCAST];
    endproperty
    a_bcast: assert property (p_bcast)
        else $error("broadcast event not latched");

    property p_start;
        start_seen |=> raw_event_status[EV_START] ##0 $fell(sda_fil);
    endproperty
    a_start: assert property (p_start)
        else $error("start event not latched");

    property p_activity_hold;
        clr_act && bus_active_in |=> raw_event_status[EV_ACTIVITY];
    endproperty
    a_activity_hold: assert property (p_activity_hold)
        else $error("activity cleared while bus active");

    property p_tx_level;
        (tx_level_ext <= transmit_threshold) |=> raw_event_status[EV_TX_LEVEL];
    endproperty
    a_tx_level: assert property (p_tx_level)
        else $error("transmit level bit wrong");

    property p_rx_level;
        (rx_level_ext < receive_threshold) |=> !raw_event_status[EV_RX_LEVEL];
    endproperty
    a_rx_level: assert property (p_rx_level)
        else $error("receive level bit set below threshold");

    property p_underflow;
        rx_read_when_empty_in ##1 !(clr_rxund || clr_all) [*2] |=>
            raw_event_status[EV_RX_UNDER];
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("underflow event lost");

    property p_clr_underflow;
        clr_rxund && !rx_read_when_empty_in |=> !raw_event_status[EV_RX_UNDER];
    endproperty
    a_clr_underflow: assert property (p_clr_underflow)
        else $error("underflow not cleared by read");

    property p_clr_abort;
        clr_abort && !transmit_abort_in |=>
            !raw_event_status[EV_ABORT] && abort_source_register == '0;
    endproperty
    a_clr_abort: assert property (p_clr_abort)
        else $error("abort read did not clear event and source");

    property p_clr_all;
        clr_all && (ev_set & ~LEVEL_BITS) == '0 |=> (raw_event_status & ~LEVEL_BITS) == '0;
    endproperty
    a_clr_all: assert property (p_clr_all)
        else $error("clear-all left a latched event");

    property p_clr_nack;
        clr_nack && !slave_tx_nack_in |=> !raw_event_status[EV_NACK];
    endproperty
    a_clr_nack: assert property (p_clr_nack)
        else $error("nack event not cleared");

    property p_irq;
        interrupt_out == |(raw_event_status & event_mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not match masked status");

    property p_rx_thr_write;
        wr_rx_thr |=> receive_threshold == $past(avs_writedata_in[THR_W-1:0]);
    endproperty
    a_rx_thr_write: assert property (p_rx_thr_write)
        else $error("receive threshold write lost");

    property p_clear_reads_zero;
        snap_rd && iec_hit(avs_address_in, OFF_CLR_START) |=>
            avs_readdata_out == '0 ##0 !avs_waitrequest_out;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero)
        else $error("clear register read not zero");

endmodule : iec_event_ctrl

/* File: verilog/iec_pkg.sv */
// iec_pkg: register map, field layout and reset values of the event status block.
// assumes a 32-bit word-addressed register bus with byte addresses on the port.
package iec_pkg;

    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int EV_W     = 12;
    localparam int THR_W    = 8;
    localparam int ABORT_W  = 17;

    typedef logic [ADDR_W-1:0] iec_addr_t;
    typedef logic [EV_W-1:0]   iec_ev_t;
    typedef logic [THR_W-1:0]  iec_thr_t;

    // register byte offsets
    localparam iec_addr_t OFF_MASKED     = 8'h2c;
    localparam iec_addr_t OFF_MASK       = 8'h30;
    localparam iec_addr_t OFF_RAW        = 8'h34;
    localparam iec_addr_t OFF_RX_THR     = 8'h38;
    localparam iec_addr_t OFF_TX_THR     = 8'h3c;
    localparam iec_addr_t OFF_CLR_ALL    = 8'h40;
    localparam iec_addr_t OFF_CLR_RXUND  = 8'h44;
    localparam iec_addr_t OFF_CLR_RXOVR  = 8'h48;
    localparam iec_addr_t OFF_CLR_TXOVR  = 8'h4c;
    localparam iec_addr_t OFF_CLR_RDREQ  = 8'h50;
    localparam iec_addr_t OFF_CLR_ABORT  = 8'h54;
    localparam iec_addr_t OFF_CLR_NACK   = 8'h58;
    localparam iec_addr_t OFF_CLR_ACT    = 8'h5c;
    localparam iec_addr_t OFF_CLR_STOP   = 8'h60;
    localparam iec_addr_t OFF_CLR_START  = 8'h64;
    localparam iec_addr_t OFF_ABORT_SRC  = 8'h80;

    // event bit positions
    localparam int EV_RX_UNDER  = 0;
    localparam int EV_RX_OVER   = 1;
    localparam int EV_RX_LEVEL  = 2;
    localparam int EV_TX_OVER   = 3;
    localparam int EV_TX_LEVEL  = 4;
    localparam int EV_RD_REQ    = 5;
    localparam int EV_ABORT     = 6;
    localparam int EV_NACK      = 7;
    localparam int EV_ACTIVITY  = 8;
    localparam int EV_STOP      = 9;
    localparam int EV_START     = 10;
    localparam int EV_BCAST     = 11;

    // bits that follow a level instead of latching
    localparam iec_ev_t LEVEL_BITS = 12'h014;

    // reset values
    localparam iec_ev_t  MASK_RST = 12'h8ff;
    localparam iec_thr_t THR_RST  = 8'h00;

    // mask byte lanes
    localparam int MASK_LO_W = 8;

endpackage : iec_pkg
